// *** rtl/port_b_pkg.sv ***
// package: register map, field codes and carriers for the port b mux block
package port_b_pkg;
    localparam int ADDR_W = 16;
    localparam logic [15:0] OFF_FSEL_LO  = 16'hf25c;
    localparam logic [15:0] OFF_FSEL_HI  = 16'hf25d;
    localparam logic [15:0] OFF_DATA     = 16'hf258;
    localparam logic [15:0] OFF_DIR      = 16'hf259;
    localparam logic [15:0] OFF_DRV_LO   = 16'hf25a;
    localparam logic [15:0] OFF_DRV_HI   = 16'hf25b;
    localparam logic [15:0] OFF_EDGE_LO  = 16'hf024;
    localparam logic [15:0] OFF_EDGE_HI  = 16'hf025;
    localparam logic [15:0] OFF_SAMP_SEL = 16'hf026;
    localparam logic [7:0]  RST_FSEL     = 8'h00;
    localparam logic [7:0]  RST_DIR      = 8'h00;
    localparam logic [7:0]  RST_DRV      = 8'h00;
    localparam logic [7:0]  RST_DATA     = 8'h00;
    localparam logic [7:0]  RST_EDGE     = 8'h00;
    localparam logic [7:0]  RST_SAMP     = 8'h00;
    localparam logic [7:0]  SAMP_MASK    = 8'h30; // pin0/pin1 sampling bits 4,5
    localparam int SAMP_BIT0 = 4;
    localparam int EDGE_BIT0 = 4;                // pins 0/1 at bits 4,5 of edge regs
    localparam int NPIN = 8;
    // function codes
    localparam logic [1:0] FN_GPIO = 2'h0;
    localparam logic [1:0] FN_ALT1 = 2'h1;
    localparam logic [1:0] FN_ALT2 = 2'h2;
    localparam logic [1:0] FN_ALT3 = 2'h3;
    // drive codes: high-z, p open drain, n open drain, cmos
    typedef enum logic [1:0] {
        DRV_HIZ  = 2'b00,
        DRV_POD  = 2'b01,
        DRV_NOD  = 2'b10,
        DRV_CMOS = 2'b11
    } drive_t;
    // edge modes
    typedef enum logic [1:0] {
        EDGE_OFF  = 2'b00,
        EDGE_FALL = 2'b01,
        EDGE_RISE = 2'b10,
        EDGE_BOTH = 2'b11
    } edge_mode_t;
    // peripheral signals muxed onto the pins
    typedef struct packed {
        logic pwm_channel_c_output;
        logic low_speed_clock_output;
        logic high_speed_clock_output;
        logic comparator0_positive_output;
        logic comparator0_negative_output;
        logic comparator1_output;
        logic serial_transmit_data;
    } periph_t;
    // per-pin pad controls
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe_n;
        logic [7:0] pull_up;
        logic [7:0] pull_down;
    } pad_t;
endpackage

// *** rtl/port_b_io_mux.sv ***
// port b pin function mux, drive control and pin 0/1 edge interrupts
// Operation
// - pin 7 codes: gpio, low-speed clock, prohibited, pwm c.
// - pin 6 codes: gpio, external clock in, two prohibited.
// - pin 5 only gpio; other codes prohibited.
// - pin 4: gpio at 00, serial transmit at 10, rest prohibited.
// - pin 3: gpio at 00, comparator 0 negative at 11.
// - pin 2: gpio at 00, comparator 0 positive at 11.
// - pin 1: gpio at 00, serial transmit at 10.
// - pin 0: gpio, pwm c, high-speed clock, comparator 1.
// - function registers reset zero; byte access, low also 16-bit.
// - prohibited output pin ignores data: high-z, or low for nod/cmos.
// - each pin's direction bit chooses input or output.
// - output drive: high-z, p open drain, n open drain, cmos.
// - input: high-z, pull-down, pull-up.
// - reset puts every pin in high-z output mode.
// - gpio output drives data register bit.
// - data read in input direction returns pin level.
// - pins 0 and 1 each have a maskable interrupt source.
// - chosen edge on pin 0 or 1 raises its request.
// - sampled mode: sample on 16k falling edge, two highs needed.
// - request on system clock after second qualifying 16k edge.
// - edge codes: off, falling, rising, both; reset off.
// - sampling bit 0 unsampled, 1 sampled by 16k clock; reset 0.
// - stopped 16k clock means no sampling.
// - direction 0 output, 1 input; drive and pull code table.
`default_nettype none
module port_b_io_mux
    import port_b_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [15:0]       wdata,
    input  wire logic              wr_en,
    input  wire logic              wr_word,
    input  wire logic              rd_en,
    output logic      [15:0]       rdata,
    input  wire logic [7:0]        pin_in,
    output pad_t                   pad,
    input  wire periph_t           periph,
    output logic                   external_clock_input,
    input  wire logic              sampling_clock_16k,
    input  wire logic              int_enable_0,
    input  wire logic              int_enable_1,
    output logic                   pin0_interrupt_request,
    output logic                   pin1_interrupt_request
);
    logic [7:0] fsel_lo_q, fsel_lo_d, fsel_hi_q, fsel_hi_d;
    logic [7:0] dir_q, dir_d, drv_lo_q, drv_lo_d, drv_hi_q, drv_hi_d;
    logic [7:0] data_q, data_d, edge_lo_q, edge_lo_d, edge_hi_q, edge_hi_d;
    logic [7:0] samp_q, samp_d;
    logic [15:0] rdata_q, rdata_d;
    logic [7:0] sync1_q, sync2_q;
    logic       clk16_s1_q, clk16_s2_q, clk16_prev_q;

    // register writes; word write at the low function address covers both
    always_comb begin
        fsel_lo_d = fsel_lo_q;
        fsel_hi_d = fsel_hi_q;
        dir_d     = dir_q;
        drv_lo_d  = drv_lo_q;
        drv_hi_d  = drv_hi_q;
        data_d    = data_q;
        edge_lo_d = edge_lo_q;
        edge_hi_d = edge_hi_q;
        samp_d    = samp_q;
        if (wr_en) begin
            case (addr)
                OFF_FSEL_LO: begin
                    fsel_lo_d = wdata[7:0];
                    if (wr_word) begin
                        fsel_hi_d = wdata[15:8];
                    end
                end
                OFF_FSEL_HI:  fsel_hi_d = wdata[7:0];
                OFF_DIR:      dir_d     = wdata[7:0];
                OFF_DRV_LO:   drv_lo_d  = wdata[7:0];
                OFF_DRV_HI:   drv_hi_d  = wdata[7:0];
                OFF_DATA:     data_d    = wdata[7:0];
                OFF_EDGE_LO:  edge_lo_d = wdata[7:0];
                OFF_EDGE_HI:  edge_hi_d = wdata[7:0];
                OFF_SAMP_SEL: samp_d    = wdata[7:0] & SAMP_MASK;
                default:      ;
            endcase
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        rdata_d = 16'h0000;
        if (rd_en) begin
            case (addr)
                OFF_FSEL_LO:  rdata_d = {fsel_hi_q, fsel_lo_q};
                OFF_FSEL_HI:  rdata_d = {8'h00, fsel_hi_q};
                OFF_DIR:      rdata_d = {8'h00, dir_q};
                OFF_DRV_LO:   rdata_d = {8'h00, drv_lo_q};
                OFF_DRV_HI:   rdata_d = {8'h00, drv_hi_q};
                OFF_DATA:     rdata_d = {8'h00, (dir_q & sync2_q) | (~dir_q & data_q)};
                OFF_EDGE_LO:  rdata_d = {8'h00, edge_lo_q};
                OFF_EDGE_HI:  rdata_d = {8'h00, edge_hi_q};
                OFF_SAMP_SEL: rdata_d = {8'h00, samp_q};
                default:      rdata_d = 16'h0000;
            endcase
        end
    end
    assign rdata = rdata_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fsel_lo_q <= RST_FSEL;
            fsel_hi_q <= RST_FSEL;
            dir_q     <= RST_DIR;
            drv_lo_q  <= RST_DRV;
            drv_hi_q  <= RST_DRV;
            data_q    <= RST_DATA;
            edge_lo_q <= RST_EDGE;
            edge_hi_q <= RST_EDGE;
            samp_q    <= RST_SAMP;
            rdata_q   <= 16'h0000;
        end else begin
            fsel_lo_q <= fsel_lo_d;
            fsel_hi_q <= fsel_hi_d;
            dir_q     <= dir_d;
            drv_lo_q  <= drv_lo_d;
            drv_hi_q  <= drv_hi_d;
            data_q    <= data_d;
            edge_lo_q <= edge_lo_d;
            edge_hi_q <= edge_hi_d;
            samp_q    <= samp_d;
            rdata_q   <= rdata_d;
        end
    end

    // pin and 16k clock synchronisers; first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q      <= 8'h00;
            sync2_q      <= 8'h00;
            clk16_s1_q   <= 1'b0;
            clk16_s2_q   <= 1'b0;
            clk16_prev_q <= 1'b0;
        end else begin
            sync1_q      <= pin_in;
            sync2_q      <= sync1_q;
            clk16_s1_q   <= sampling_clock_16k;
            clk16_s2_q   <= clk16_s1_q;
            clk16_prev_q <= clk16_s2_q;
        end
    end

    // no 16k falling edge means no samples
    logic clk16_fall;
    assign clk16_fall = clk16_prev_q & ~clk16_s2_q;
    // external clock input passes the synchronised pin 6 level
    assign external_clock_input = (fsel_hi_q[6] == 1'b0 && fsel_lo_q[6] == 1'b1)
                                  ? sync2_q[6] : 1'b0;

    // per-pin function decode and pad drive
    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_pin
            logic [1:0] code;
            logic       alt_ok, alt_val, src, is_in;
            drive_t     drv;
            assign code  = {fsel_hi_q[g], fsel_lo_q[g]};
            assign is_in = dir_q[g];
            assign drv   = drive_t'({drv_hi_q[g], drv_lo_q[g]});
            always_comb begin
                alt_ok  = 1'b0;
                alt_val = 1'b0;
                if (code == FN_GPIO) begin
                    alt_ok = 1'b1;
                end else begin
                    case (g)
                        7: begin
                            alt_ok  = (code != FN_ALT2);
                            alt_val = (code == FN_ALT1) ? periph.low_speed_clock_output
                                                        : periph.pwm_channel_c_output;
                        end
                        // pin 6 external clock is an input function
                        6: begin
                            alt_ok  = (code == FN_ALT1);
                            alt_val = data_q[g];
                        end
                        5: alt_ok = 1'b0;
                        4, 1: begin
                            alt_ok  = (code == FN_ALT2);
                            alt_val = periph.serial_transmit_data;
                        end
                        3: begin
                            alt_ok  = (code == FN_ALT3);
                            alt_val = periph.comparator0_negative_output;
                        end
                        2: begin
                            alt_ok  = (code == FN_ALT3);
                            alt_val = periph.comparator0_positive_output;
                        end
                        0: begin
                            alt_ok = 1'b1;
                            case (code)
                                FN_ALT1: alt_val = periph.pwm_channel_c_output;
                                FN_ALT2: alt_val = periph.high_speed_clock_output;
                                default: alt_val = periph.comparator1_output;
                            endcase
                        end
                        default: alt_ok = 1'b0;
                    endcase
                end
            end
            // gpio drives the data bit; prohibited forces low
            assign src = (code == FN_GPIO) ? data_q[g] : (alt_ok ? alt_val : 1'b0);
            always_comb begin
                pad.out[g]       = 1'b0;
                pad.oe_n[g]      = 1'b1;
                pad.pull_up[g]   = 1'b0;
                pad.pull_down[g] = 1'b0;
                if (is_in) begin
                    pad.pull_down[g] = (drv == DRV_POD);
                    pad.pull_up[g]   = (drv == DRV_NOD);
                end else begin
                    case (drv)
                        DRV_POD: begin
                            pad.out[g]  = 1'b1;
                            pad.oe_n[g] = ~(src & alt_ok);
                        end
                        DRV_NOD: begin
                            pad.out[g]  = 1'b0;
                            pad.oe_n[g] = src;
                        end
                        DRV_CMOS: begin
                            pad.out[g]  = src;
                            pad.oe_n[g] = 1'b0;
                        end
                        default: pad.oe_n[g] = 1'b1;
                    endcase
                end
            end
        end
    endgenerate

    // edge detection for pins 0 and 1
    logic [1:0] prev_q, prev_d, samp_a_q, samp_a_d, samp_b_q, samp_b_d;
    logic [1:0] irq_q, irq_d;
    always_comb begin
        prev_d   = sync2_q[1:0];
        samp_a_d = samp_a_q;
        samp_b_d = samp_b_q;
        irq_d    = 2'b00;
        for (int i = 0; i < 2; i++) begin
            edge_mode_t m;
            logic       rise, fall, en;
            m  = edge_mode_t'({edge_hi_q[EDGE_BIT0 + i], edge_lo_q[EDGE_BIT0 + i]});
            en = (i == 0) ? int_enable_0 : int_enable_1;
            if (samp_q[SAMP_BIT0 + i]) begin
                rise = 1'b0;
                fall = 1'b0;
                if (clk16_fall) begin
                    samp_a_d[i] = sync2_q[i];
                    samp_b_d[i] = samp_a_q[i];
                    rise = sync2_q[i] & samp_a_q[i] & ~samp_b_q[i];
                    fall = ~sync2_q[i] & ~samp_a_q[i] & samp_b_q[i];
                end
            end else begin
                rise = sync2_q[i] & ~prev_q[i];
                fall = ~sync2_q[i] & prev_q[i];
            end
            // selected edge raises request; enable gates
            case (m)
                EDGE_FALL: irq_d[i] = en & fall;
                EDGE_RISE: irq_d[i] = en & rise;
                EDGE_BOTH: irq_d[i] = en & (rise | fall);
                default:   irq_d[i] = 1'b0;
            endcase
        end
    end

    // request one clock after the qualifying 16k edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_q   <= 2'b00;
            samp_a_q <= 2'b00;
            samp_b_q <= 2'b00;
            irq_q    <= 2'b00;
        end else begin
            prev_q   <= prev_d;
            samp_a_q <= samp_a_d;
            samp_b_q <= samp_b_d;
            irq_q    <= irq_d;
        end
    end
    assign pin0_interrupt_request = irq_q[0];
    assign pin1_interrupt_request = irq_q[1];
endmodule
`default_nettype wire

// *** bench/port_b_io_mux_assertions.sv ***
// checker: pad and interrupt relations of the port b mux
`default_nettype none
module port_b_io_mux_assertions
    import port_b_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        rd_en,
    input wire logic [15:0] rdata,
    input wire logic [7:0]  pin_in,
    input wire pad_t        pad,
    input wire logic        external_clock_input,
    input wire logic        sampling_clock_16k,
    input wire logic        int_enable_0,
    input wire logic        int_enable_1,
    input wire logic        pin0_interrupt_request,
    input wire logic        pin1_interrupt_request
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // read data stand only in the cycle after a read
    property p_rd_idle; !$past(rd_en) |-> rdata == 16'h0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata not zero when idle");
    property p_rst_hiz;
        $past(!rst_n) |-> pad.oe_n == 8'hff && (pad.pull_up | pad.pull_down) == 8'h00;
    endproperty
    a_rst_hiz: assert property (p_rst_hiz) else $error("pads not high-z after reset");
    property p_drv_nopull; (~pad.oe_n & (pad.pull_up | pad.pull_down)) == 8'h00; endproperty
    a_drv_nopull: assert property (p_drv_nopull) else $error("pull on driven pin");
    property p_pull_excl; (pad.pull_up & pad.pull_down) == 8'h00; endproperty
    a_pull_excl: assert property (p_pull_excl) else $error("pull up and down together");
    // two flops of synchroniser between pin 6 and the clock input
    property p_ext_clk; external_clock_input |-> $past(pin_in[6], 2); endproperty
    a_ext_clk: assert property (p_ext_clk) else $error("clock input not pin level");
    property p_pulse0; pin0_interrupt_request |=> !pin0_interrupt_request; endproperty
    a_pulse0: assert property (p_pulse0) else $error("pin0 request longer than one");
    property p_mask0; pin0_interrupt_request |-> int_enable_0; endproperty
    a_mask0: assert property (p_mask0) else $error("masked pin0 request");
    property p_mask1; pin1_interrupt_request |-> int_enable_1; endproperty
    a_mask1: assert property (p_mask1) else $error("masked pin1 request");
    // no edge and no sampling tick means no request
    sequence s_still0; ($stable(pin_in[0]) && $stable(sampling_clock_16k)) [*8]; endsequence
    property p_quiet0; s_still0 |=> !pin0_interrupt_request; endproperty
    a_quiet0: assert property (p_quiet0) else $error("pin0 request without edge");
    c_irq0: cover property (pin0_interrupt_request);
    c_irq1: cover property (pin1_interrupt_request);
    c_ext: cover property (external_clock_input);
endmodule
bind port_b_io_mux port_b_io_mux_assertions u_chk (.clk, .rst_n, .rd_en, .rdata, .pin_in,
    .pad, .external_clock_input, .sampling_clock_16k, .int_enable_0, .int_enable_1,
    .pin0_interrupt_request, .pin1_interrupt_request);
`default_nettype wire

// *** bench/pin_side_model.sv ***
// pin side model: resolves pad drive, pulls and outside drivers
`default_nettype none
module pin_side_model
    import port_b_pkg::*;
(
    input  wire logic       clk,
    input  wire pad_t       pad,
    input  wire logic [7:0] ext_drv,
    input  wire logic [7:0] ext_lvl,
    output logic      [7:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] float_q = 8'h00;
    // an open pin wanders so a stale level never reads as valid
    always_ff @(posedge clk) float_q <= ~pin_in;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pad.oe_n[i]) pin_in[i] = pad.out[i];
            else if (ext_drv[i]) pin_in[i] = ext_lvl[i];
            else if (pad.pull_up[i]) pin_in[i] = 1'h1;
            else if (pad.pull_down[i]) pin_in[i] = 1'h0;
            else pin_in[i] = float_q[i];
        end
    end
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// testbench: registers, drive modes, function mux and pin interrupts
`default_nettype none
module tb_top
    import port_b_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] MAP [9] = '{OFF_FSEL_LO, OFF_FSEL_HI, OFF_DATA, OFF_DIR,
        OFF_DRV_LO, OFF_DRV_HI, OFF_EDGE_LO, OFF_EDGE_HI, OFF_SAMP_SEL};
    localparam logic [7:0] PROH [4] = '{8'h00, 8'h3e, 8'hec, 8'h72};
    logic        clk, rst_n, wr_en, wr_word, rd_en, s16, en0, en1, samp_run, ext_o, irq0, irq1;
    logic [15:0] addr, wdata, rdata;
    logic [7:0]  pin_in, ext_drv, ext_lvl;
    pad_t        pad;
    periph_t     periph;
    int          err_count, samples_checked, n0, n1;
    port_b_io_mux u_dut (.clk, .rst_n, .addr, .wdata, .wr_en, .wr_word, .rd_en, .rdata,
        .pin_in, .pad, .periph, .external_clock_input(ext_o), .sampling_clock_16k(s16),
        .int_enable_0(en0), .int_enable_1(en1), .pin0_interrupt_request(irq0),
        .pin1_interrupt_request(irq1));
    pin_side_model u_pins (.clk, .pad, .ext_drv, .ext_lvl, .pin_in);
    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    // 16k clock: 2500 system clocks a period, held still in stop mode
    initial forever begin
        repeat (1250) @(posedge clk);
        if (samp_run) s16 <= ~s16;
    end
    // request pulses are counted, so a doubled pulse shows up
    always @(posedge clk) begin
        if (irq0 === 1'h1) n0 <= n0 + 1;
        if (irq1 === 1'h1) n1 <= n1 + 1;
    end
    // the run needs about 20000 clocks; three times that means a hang
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        give_verdict();
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(logic [15:0] a, logic [15:0] d, logic w = 1'h0);
        @(posedge clk);
        wr_en <= 1'h1;
        addr <= a;
        wdata <= d;
        wr_word <= w;
        @(posedge clk);
        wr_en <= 1'h0;
        wr_word <= 1'h0;
        #1;
    endtask
    task automatic rd(string n, logic [15:0] a, logic [15:0] e);
        @(posedge clk);
        rd_en <= 1'h1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'h0;
        #1 chk(n, e, rdata);
    endtask
    function automatic logic [7:0] exp_out(int c, periph_t s);
        case (c)
            0: return 8'hff;
            1: return {s.low_speed_clock_output, 1'h1, 5'h00, s.pwm_channel_c_output};
            2: return {3'h0, s.serial_transmit_data, 2'h0, s.serial_transmit_data,
                s.high_speed_clock_output};
            default: return {s.pwm_channel_c_output, 3'h0, s.comparator0_negative_output,
                s.comparator0_positive_output, 1'h0, s.comparator1_output};
        endcase
    endfunction
    task automatic t_regs;
        foreach (MAP[i]) rd("reset value", MAP[i], 16'h0000);
        chk("reset oe_n", 16'h00ff, {8'h00, pad.oe_n});
        wr(OFF_FSEL_LO, 16'h5aa5, 1'h1);
        rd("fsel word", OFF_FSEL_LO, 16'h5aa5);
        wr(OFF_FSEL_LO, 16'h00c3);
        rd("fsel byte", OFF_FSEL_LO, 16'h5ac3);
        rd("fsel high", OFF_FSEL_HI, 16'h005a);
        wr(16'hf25e, 16'h00ff);
        rd("unmapped", 16'hf25e, 16'h0000);
        wr(OFF_SAMP_SEL, 16'h00ff);
        rd("sampling bits", OFF_SAMP_SEL, 16'h0030);
        // back to unsampled detection so the edge test sees direct edges
        wr(OFF_SAMP_SEL, 16'h0000);
        wr(OFF_FSEL_LO, 16'h0000, 1'h1);
        $display("test regs done");
    endtask
    task automatic t_drive;
        logic [7:0] e;
        wr(OFF_DATA, 16'h00a5);
        for (int c = 0; c < 4; c++) begin
            wr(OFF_DRV_LO, c[0] ? 16'h00ff : 16'h0000);
            wr(OFF_DRV_HI, c[1] ? 16'h00ff : 16'h0000);
            e = c == 0 ? 8'hff : c == 1 ? 8'h5a : c == 2 ? 8'ha5 : 8'h00;
            chk("drive oe_n", {8'h00, e}, {8'h00, pad.oe_n});
            chk("drive out", {8'h00, 8'ha5 & ~e}, {8'h00, pad.out & ~e});
        end
        // low nibble input, high nibble output, pull and open-drain codes
        wr(OFF_DIR, 16'h000f);
        wr(OFF_DRV_HI, 16'h0000);
        chk("mixed pod", 16'h5f0f, {pad.oe_n, pad.pull_down});
        wr(OFF_DRV_LO, 16'h0000);
        wr(OFF_DRV_HI, 16'h00ff);
        chk("mixed nod", 16'haf0f, {pad.oe_n, pad.pull_up});
        ext_drv <= 8'hff;
        ext_lvl <= 8'h3c;
        wr(OFF_DIR, 16'h00ff);
        repeat (3) @(posedge clk);
        rd("pin levels", OFF_DATA, 16'h003c);
        $display("test drive done");
    endtask
    task automatic t_mux;
        wr(OFF_DIR, 16'h0000);
        wr(OFF_DATA, 16'h00ff);
        wr(OFF_DRV_LO, 16'h00ff);
        for (int c = 0; c < 4; c++) begin
            wr(OFF_FSEL_LO, {{8{c[1]}}, {8{c[0]}}}, 1'h1);
            for (int k = 0; k < 7; k++) begin
                periph <= periph_t'(7'h01 << k);
                @(posedge clk);
                #1 chk("mux out", {8'h00, exp_out(c, periph)}, {8'h00, pad.out});
                chk("mux oe_n", 16'h0000, {8'h00, pad.oe_n});
            end
            chk("clock input", {15'h0, c == 1}, {15'h0, ext_o});
            wr(OFF_DRV_HI, 16'h0000);
            chk("prohibited pod", {8'h00, PROH[c]}, {8'h00, pad.oe_n & PROH[c]});
            wr(OFF_DRV_HI, 16'h00ff);
        end
        wr(OFF_FSEL_LO, 16'h0000, 1'h1);
        wr(OFF_DRV_LO, 16'h0000);
        wr(OFF_DRV_HI, 16'h0000);
        $display("test mux done");
    endtask
    task automatic t_edges;
        int a0;
        int a1;
        for (int m = 0; m < 4; m++) begin
            wr(OFF_EDGE_LO, m[0] ? 16'h0030 : 16'h0000);
            wr(OFF_EDGE_HI, m[1] ? 16'h0030 : 16'h0000);
            en0 <= m != 3;
            a0 = n0;
            a1 = n1;
            ext_lvl <= 8'h3f;
            repeat (10) @(posedge clk);
            ext_lvl <= 8'h3c;
            repeat (10) @(posedge clk);
            #1 chk("pin0 pulses", 16'(m == 3 ? 0 : m[0] + m[1]), 16'(n0 - a0));
            chk("pin1 pulses", 16'(int'(m[0]) + int'(m[1])), 16'(n1 - a1));
        end
        en0 <= 1'h1;
        $display("test edges done");
    endtask
    task automatic t_sampled;
        int a0;
        wr(OFF_SAMP_SEL, 16'h0030);
        wr(OFF_EDGE_LO, 16'h0000);
        @(negedge s16);
        repeat (4) @(posedge clk);
        a0 = n0;
        ext_lvl <= 8'h3f;
        @(negedge s16);
        repeat (8) @(posedge clk);
        #1 chk("one high sample", 16'h0000, 16'(n0 - a0));
        @(negedge s16);
        repeat (8) @(posedge clk);
        #1 chk("two high samples", 16'h0001, 16'(n0 - a0));
        ext_lvl <= 8'h3c;
        repeat (2) @(negedge s16);
        samp_run <= 1'h0;
        repeat (1300) @(posedge clk);
        a0 = n0;
        ext_lvl <= 8'h3f;
        repeat (6000) @(posedge clk);
        #1 chk("stopped sampling", 16'h0000, 16'(n0 - a0));
        $display("test sampled done");
    endtask
    initial begin
        {rst_n, wr_en, wr_word, rd_en, s16, n0, n1, err_count, samples_checked} = '0;
        {en0, en1, samp_run} = 3'h7;
        {addr, wdata, ext_drv, ext_lvl} = '0;
        periph = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
        t_regs();
        t_drive();
        t_mux();
        t_edges();
        t_sampled();
        give_verdict();
    end
endmodule
`default_nettype wire
